// ### inc/hbav_consts.svh
`ifndef HBAV_CONSTS_SVH
`define HBAV_CONSTS_SVH

// Register addresses.
`define ADDR_BRAKE_OFFSET 8'h10
`define ADDR_VIBE_CONTROL 8'h11
`define ADDR_INPUT_FLOOR 8'h12
`define ADDR_INPUT_CEILING 8'h13
`define ADDR_DRIVE_FLOOR 8'h14
`define ADDR_DRIVE_CEILING 8'h15
`define ADDR_NOMINAL_LEVEL 8'h16

// Reset values.
`define RST_BRAKE_OFFSET 8'h00
`define RST_PEAK_WINDOW 2'h1
`define RST_LOWPASS 2'h1
`define RST_INPUT_FLOOR 8'h19
`define RST_INPUT_CEILING 8'hff
`define RST_DRIVE_FLOOR 8'h19
`define RST_DRIVE_CEILING 8'hff
`define RST_NOMINAL_LEVEL 8'h3f

// Control register field positions.
`define PEAK_HI 3
`define PEAK_LO 2
`define LPF_HI 1
`define LPF_LO 0

// Decoded settings.
`define PEAK_MS_0 8'h0a
`define PEAK_MS_1 8'h14
`define PEAK_MS_2 8'h1e
`define PEAK_MS_3 8'h28
`define LPF_HZ_0 8'h64
`define LPF_HZ_1 8'h7d
`define LPF_HZ_2 8'h96
`define LPF_HZ_3 8'hc8

// Misc constants.
`define ZERO_BYTE 8'h00
`define ZERO_TIME 16'h0000
`define LEVEL_MAX 8'sh7f

`endif

// ### inc/hbav_pkg.sv
package hbav_pkg;
    typedef logic [7:0] byte_t;
    typedef logic signed [7:0] level_t;
    typedef logic [15:0] time_t;
endpackage : hbav_pkg

// ### rtl/haptic_brake_audio_vibe_regs.sv
`include "hbav_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module haptic_brake_audio_vibe_regs
    import hbav_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_b,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // Operating mode and shared settings.
    input wire logic closed_loop,
    input wire logic [7:0] waveform_step_period,
    input wire logic [7:0] open_loop_reference,
    // Waveform scan and playback segments.
    input wire logic scan_start,
    input wire logic scan_valid,
    input wire logic signed [7:0] scan_level,
    input wire logic seg_valid,
    input wire logic signed [7:0] seg_level,
    input wire logic [15:0] seg_time,
    output logic seg_out_valid,
    output logic seg_is_brake,
    output logic [15:0] seg_out_time,
    // Audio path.
    input wire logic audio_valid,
    input wire logic [7:0] analog_or_trigger_input,
    output logic drive_valid,
    output logic [7:0] drive_level,
    // Decoded settings.
    output logic [7:0] peak_window_ms,
    output logic [7:0] lowpass_hz,
    output logic [7:0] full_scale_reference,
    output logic [7:0] calibration_level
);

    level_t brake_offset_field;
    logic [1:0] vibe_peak_window;
    logic [1:0] vibe_lowpass_select;
    byte_t vibe_input_floor;
    byte_t vibe_input_ceiling;
    byte_t vibe_drive_floor;
    byte_t vibe_drive_ceiling;
    byte_t actuator_nominal_level;
    level_t brake_level;
    logic signed [16:0] next_time;

    function automatic logic [7:0] peak_ms(input logic [1:0] code);
        unique case (code)
            2'h0: peak_ms = `PEAK_MS_0;
            2'h1: peak_ms = `PEAK_MS_1;
            2'h2: peak_ms = `PEAK_MS_2;
            2'h3: peak_ms = `PEAK_MS_3;
        endcase
    endfunction : peak_ms

    function automatic logic [7:0] lpf_hz(input logic [1:0] code);
        unique case (code)
            2'h0: lpf_hz = `LPF_HZ_0;
            2'h1: lpf_hz = `LPF_HZ_1;
            2'h2: lpf_hz = `LPF_HZ_2;
            2'h3: lpf_hz = `LPF_HZ_3;
        endcase
    endfunction : lpf_hz

    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
        wr_hit = reg_wr && (a == target);
    endfunction : wr_hit

    // Register writes.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            brake_offset_field <= `RST_BRAKE_OFFSET;
            vibe_peak_window <= `RST_PEAK_WINDOW;
            vibe_lowpass_select <= `RST_LOWPASS;
            vibe_input_floor <= `RST_INPUT_FLOOR;
            vibe_input_ceiling <= `RST_INPUT_CEILING;
            vibe_drive_floor <= `RST_DRIVE_FLOOR;
            vibe_drive_ceiling <= `RST_DRIVE_CEILING;
            actuator_nominal_level <= `RST_NOMINAL_LEVEL;
        end else begin
            if (wr_hit(reg_addr, `ADDR_BRAKE_OFFSET)) begin
                brake_offset_field <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ADDR_VIBE_CONTROL)) begin
                vibe_peak_window <= reg_wdata[`PEAK_HI:`PEAK_LO];
                vibe_lowpass_select <= reg_wdata[`LPF_HI:`LPF_LO];
            end
            if (wr_hit(reg_addr, `ADDR_INPUT_FLOOR)) begin
                vibe_input_floor <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ADDR_INPUT_CEILING)) begin
                vibe_input_ceiling <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ADDR_DRIVE_FLOOR)) begin
                vibe_drive_floor <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ADDR_DRIVE_CEILING)) begin
                vibe_drive_ceiling <= reg_wdata;
            end
            if (wr_hit(reg_addr, `ADDR_NOMINAL_LEVEL)) begin
                actuator_nominal_level <= reg_wdata;
            end
        end
    end

    // Register reads; reserved bits and unmapped addresses read zero.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reg_rdata <= `ZERO_BYTE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_addr)
                    `ADDR_BRAKE_OFFSET: reg_rdata <= brake_offset_field;
                    `ADDR_VIBE_CONTROL: reg_rdata <= {4'h0, vibe_peak_window, vibe_lowpass_select};
                    `ADDR_INPUT_FLOOR: reg_rdata <= vibe_input_floor;
                    `ADDR_INPUT_CEILING: reg_rdata <= vibe_input_ceiling;
                    `ADDR_DRIVE_FLOOR: reg_rdata <= vibe_drive_floor;
                    `ADDR_DRIVE_CEILING: reg_rdata <= vibe_drive_ceiling;
                    `ADDR_NOMINAL_LEVEL: reg_rdata <= actuator_nominal_level;
                    default: reg_rdata <= `ZERO_BYTE;
                endcase
            end
        end
    end

    // Scan tracks the most negative level of the waveform.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            brake_level <= `LEVEL_MAX;
        end else if (scan_start) begin
            brake_level <= `LEVEL_MAX;
        end else if (scan_valid && (scan_level < brake_level)) begin
            brake_level <= scan_level;
        end
    end

    // Offset in ms is the signed field times the step period.
    always_comb begin
        next_time = $signed({1'b0, seg_time});
        if (!closed_loop && (seg_level == brake_level)) begin
            next_time = 17'($signed({1'b0, seg_time})
                + brake_offset_field * $signed({1'b0, waveform_step_period}));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            seg_out_valid <= 1'b0;
            seg_is_brake <= 1'b0;
            seg_out_time <= `ZERO_TIME;
        end else begin
            seg_out_valid <= seg_valid;
            if (seg_valid) begin
                seg_is_brake <= (seg_level == brake_level);
                seg_out_time <= next_time[16] ? `ZERO_TIME : next_time[15:0];
            end
        end
    end

    // Audio drive: ignore below floor, saturate at ceiling, clamp drive window.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            drive_valid <= 1'b0;
            drive_level <= `ZERO_BYTE;
        end else begin
            drive_valid <= audio_valid;
            if (audio_valid) begin
                if (analog_or_trigger_input < vibe_input_floor) begin
                    drive_level <= `ZERO_BYTE;
                end else if (analog_or_trigger_input >= vibe_input_ceiling) begin
                    drive_level <= vibe_drive_ceiling;
                end else if (analog_or_trigger_input < vibe_drive_floor) begin
                    drive_level <= vibe_drive_floor;
                end else if (analog_or_trigger_input > vibe_drive_ceiling) begin
                    drive_level <= vibe_drive_ceiling;
                end else begin
                    drive_level <= analog_or_trigger_input;
                end
            end
        end
    end

    // Decoded settings and full-scale reference.
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            peak_window_ms <= `PEAK_MS_1;
            lowpass_hz <= `LPF_HZ_1;
            full_scale_reference <= `ZERO_BYTE;
            calibration_level <= `RST_NOMINAL_LEVEL;
        end else begin
            peak_window_ms <= peak_ms(vibe_peak_window);
            lowpass_hz <= lpf_hz(vibe_lowpass_select);
            full_scale_reference <= closed_loop ? actuator_nominal_level
                : open_loop_reference;
            calibration_level <= actuator_nominal_level;
        end
    end

    sequence s_write_ctrl;
        reg_wr && (reg_addr == `ADDR_VIBE_CONTROL);
    endsequence

    sequence s_brake_seg_open;
        seg_valid && !closed_loop && (seg_level == brake_level);
    endsequence

    a_brake_scaled: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_brake_seg_open ##0 (($signed({1'b0, seg_time})
            + brake_offset_field * $signed({1'b0, waveform_step_period})) >= 0)
        |=> seg_out_time == 16'($signed({1'b0, $past(seg_time)})
            + $past(brake_offset_field) * $signed({1'b0, $past(waveform_step_period)})))
        else $error("brake time not scaled by offset");
    a_closed_loop_plain: assert property (@(posedge core_clk) disable iff (!rst_b)
        seg_valid && closed_loop |=> seg_out_time == $past(seg_time))
        else $error("offset applied in closed loop");
    a_brake_flag: assert property (@(posedge core_clk) disable iff (!rst_b)
        seg_valid |=> seg_is_brake == ($past(seg_level) == $past(brake_level)))
        else $error("brake segment flag wrong");
    a_peak_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_write_ctrl ##0 (reg_wdata[`PEAK_HI:`PEAK_LO] == 2'h3) |=> ##1 peak_window_ms == `PEAK_MS_3)
        else $error("peak window decode wrong");
    a_lpf_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
        s_write_ctrl ##0 (reg_wdata[`LPF_HI:`LPF_LO] == 2'h0) |=> ##1 lowpass_hz == `LPF_HZ_0)
        else $error("low-pass decode wrong");
    a_input_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
        audio_valid && (analog_or_trigger_input < vibe_input_floor) |=> drive_level == 8'h00)
        else $error("input below floor not ignored");
    a_drive_floor: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_valid && (drive_level != 8'h00) && ($past(vibe_drive_floor) <= $past(vibe_drive_ceiling))
        |-> drive_level >= $past(vibe_drive_floor))
        else $error("drive below floor");
    a_drive_ceiling: assert property (@(posedge core_clk) disable iff (!rst_b)
        drive_valid |-> drive_level <= $past(vibe_drive_ceiling))
        else $error("drive above ceiling");
    a_full_scale: assert property (@(posedge core_clk) disable iff (!rst_b)
        audio_valid && (analog_or_trigger_input >= vibe_input_floor)
        && (analog_or_trigger_input >= vibe_input_ceiling) |=> drive_level == $past(vibe_drive_ceiling))
        else $error("full-scale input not saturated");
    a_reference_mode: assert property (@(posedge core_clk) disable iff (!rst_b)
        closed_loop ##1 closed_loop |-> full_scale_reference == $past(actuator_nominal_level))
        else $error("closed-loop reference wrong");

endmodule : haptic_brake_audio_vibe_regs
`default_nettype wire

// ### tb/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock.
    input wire logic core_clk,
    // Register port.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Holds the request for one edge, then shows the inverse on the released bus.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask : rd
endmodule : host_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import hbav_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, closed_loop = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, drive_level, peak_window_ms, lowpass_hz;
    logic reg_wr, reg_rd, reg_rvalid, seg_out_valid, seg_is_brake, drive_valid;
    logic [7:0] step = 8'h00, ol_ref = 8'h00, ain = 8'h00, fsr, cal_lvl, n;
    logic scan_start = 1'b0, scan_valid = 1'b0, seg_valid = 1'b0, audio_valid = 1'b0;
    logic signed [7:0] scan_level = 8'sh00, seg_level = 8'sh00;
    logic [15:0] seg_time = 16'h0000, seg_out_time;
    logic [31:0] q_rd[$], q_seg[$], q_dv[$];
    int err_total = 0, n_compared = 0, cycles = 0;
    logic [7:0] rst_v[8] = '{8'h00, 8'h05, 8'h19, 8'hff, 8'h19, 8'hff, 8'h3f, 8'h00};
    logic [7:0] lpf_v[4] = '{8'h64, 8'h7d, 8'h96, 8'hc8};
    logic [7:0] ain_v[5] = '{8'h10, 8'hc0, 8'h25, 8'hb0, 8'h50};
    haptic_brake_audio_vibe_regs i_haptic_brake_audio_vibe_regs (.core_clk(core_clk),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .closed_loop(closed_loop), .waveform_step_period(step), .open_loop_reference(ol_ref),
        .scan_start(scan_start), .scan_valid(scan_valid), .scan_level(scan_level),
        .seg_valid(seg_valid), .seg_level(seg_level), .seg_time(seg_time),
        .seg_out_valid(seg_out_valid), .seg_is_brake(seg_is_brake), .seg_out_time(seg_out_time),
        .audio_valid(audio_valid), .analog_or_trigger_input(ain), .drive_valid(drive_valid),
        .drive_level(drive_level), .peak_window_ms(peak_window_ms), .lowpass_hz(lowpass_hz),
        .full_scale_reference(fsr), .calibration_level(cal_lvl));
    host_model i_host_model (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));
    initial begin
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic complete_run();
        $display("errors=%0d compared=%0d", err_total, n_compared);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        i_host_model.wr(a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        q_rd.push_back({24'h0, e});
        @(posedge core_clk);
        i_host_model.rd(a);
    endtask : rd
    // Expected drive after the floor and ceiling clamps, in priority order.
    function automatic logic [7:0] exp_drv(input logic [7:0] x);
        if (x < 8'h20) return 8'h00;
        if (x >= 8'hc0) return 8'ha0;
        if (x < 8'h30) return 8'h30;
        if (x > 8'ha0) return 8'ha0;
        return x;
    endfunction : exp_drv
    task automatic audio(input logic [7:0] x);
        @(posedge core_clk);
        q_dv.push_back({24'h0, exp_drv(x)});
        audio_valid <= 1'b1;
        ain <= x;
        @(posedge core_clk);
        audio_valid <= 1'b0;
        ain <= ~x;
    endtask : audio
    task automatic seg(input logic signed [7:0] lv, input logic [15:0] t, input logic cl,
                       input logic signed [7:0] off, input logic [7:0] per);
        int tm;
        tm = int'(t);
        if (lv == -8'sd100 && !cl) tm = tm + int'(off) * int'(per);
        if (tm < 0) tm = 0;
        wr(8'h10, off);
        @(posedge core_clk);
        q_seg.push_back({15'h0, lv == -8'sd100, tm[15:0]});
        closed_loop <= cl;
        step <= per;
        seg_valid <= 1'b1;
        seg_level <= lv;
        seg_time <= t;
        @(posedge core_clk);
        seg_valid <= 1'b0;
    endtask : seg
    always @(negedge core_clk) begin
        if (reg_rvalid) check(reg_rdata, q_rd.pop_front());
        if (seg_out_valid) check({seg_is_brake, seg_out_time}, q_seg.pop_front());
        if (drive_valid) check(drive_level, q_dv.pop_front());
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(79164));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        check(peak_window_ms, 8'h14);
        check(lowpass_hz, 8'h7d);
        for (int i = 0; i < 8; i++) rd(8'h10 + i[7:0], rst_v[i]);
        for (int p = 0; p < 4; p++) begin
            for (int l = 0; l < 4; l++) begin
                wr(8'h11, {4'hf, p[1:0], l[1:0]});
                rd(8'h11, {4'h0, p[1:0], l[1:0]});
                @(posedge core_clk);
                check(peak_window_ms, 8'd10 * (p[7:0] + 8'd1));
                check(lowpass_hz, lpf_v[l]);
            end
        end
        for (int i = 2; i < 7; i++) begin
            n = 8'($urandom);
            wr(8'h10 + i[7:0], n);
            rd(8'h10 + i[7:0], n);
        end
        wr(8'h17, 8'h55);
        rd(8'h17, 8'h00);
        n = 8'($urandom);
        ol_ref <= ~n;
        wr(8'h16, n);
        closed_loop <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(fsr, n);
        check(cal_lvl, n);
        closed_loop <= 1'b0;
        repeat (3) @(posedge core_clk);
        check(fsr, 8'(~n));
        wr(8'h12, 8'h20);
        wr(8'h13, 8'hc0);
        wr(8'h14, 8'h30);
        wr(8'h15, 8'ha0);
        for (int i = 0; i < 5; i++) audio(ain_v[i]);
        for (int i = 0; i < 6; i++) audio(8'($urandom));
        @(posedge core_clk);
        scan_start <= 1'b1;
        @(posedge core_clk);
        scan_start <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            scan_valid <= 1'b1;
            scan_level <= (i == 1) ? -8'sd100 : 8'sd10 - 8'(i * 30);
            @(posedge core_clk);
        end
        scan_valid <= 1'b0;
        seg(-8'sd100, 16'd100, 1'b0, -8'sd2, 8'd5);
        seg(-8'sd100, 16'd50, 1'b0, 8'sd127, 8'd3);
        seg(-8'sd100, 16'd10, 1'b0, -8'sd128, 8'd200);
        seg(-8'sd100, 16'd100, 1'b1, -8'sd2, 8'd5);
        seg(-8'sd50, 16'd70, 1'b0, -8'sd2, 8'd5);
        repeat (4) @(posedge core_clk);
        check(q_rd.size() + q_seg.size() + q_dv.size(), 0);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
